// ===== core/cpu_addr_map.vh
// Constants for the CPU address-forming and instruction-class sequencer
`ifndef CPU_ADDR_MAP_VH
`define CPU_ADDR_MAP_VH

// ----------------------------------------------------------------
// Reset values, page-zero high byte and step sizes
// ----------------------------------------------------------------
`define RESET_PC      16'h0100
`define RESET_SP      8'hFF
`define PAGE0_HIGH    8'h00
`define PC_STEP       16'h0001
`define SP_STEP       8'h01

// ----------------------------------------------------------------
// Addressing mode, opcode bits 7:4
// ----------------------------------------------------------------
`define MODE_BITBR    4'h0
`define MODE_BITOP    4'h1
`define MODE_REL      4'h2
`define MODE_RMW_DIR  4'h3
`define MODE_INH_A    4'h4
`define MODE_INH_X    4'h5
`define MODE_RMW_IX1  4'h6
`define MODE_RMW_IX   4'h7
`define MODE_IMM      4'hA
`define MODE_DIR      4'hB
`define MODE_EXT      4'hC
`define MODE_IX2      4'hD
`define MODE_IX1      4'hE
`define MODE_IX       4'hF

// ----------------------------------------------------------------
// Operation, opcode bits 3:0; multiply is a whole 8-bit opcode
// ----------------------------------------------------------------
`define OP_MUL        8'h42
`define FN_AND        4'h4
`define FN_LDA        4'h6
`define FN_STA        4'h7
`define FN_ADC        4'h9
`define FN_ADD        4'hB
`define FN_JMP        4'hC
`define FN_JSR        4'hD
`define FN_LDX        4'hE
`define FN_STX        4'hF
`define FN_COM        4'h3
`define FN_DEC        4'hA
`define FN_INC        4'hC
`define FN_TST        4'hD
`define FN_CLR        4'hF
`define BR_ALWAYS     4'h0
`define BR_NEVER      4'h1
`define BR_CC         4'h4
`define BR_CS         4'h5
`define BR_NE         4'h6
`define BR_EQ         4'h7

`endif

// ===== core/ea_unit.v
// Effective address former for all memory addressing modes
`timescale 1ns/1ps
`default_nettype none
`include "cpu_addr_map.vh"

module ea_unit (
  input  wire [3:0]  addr_mode,
  input  wire [7:0]  byte1,
  input  wire [7:0]  byte2,
  input  wire [7:0]  index,
  output reg  [15:0] eff_addr
);

  // ----------------------------------------------------------------
  // Address forming
  // ----------------------------------------------------------------
  // Unsigned sums only; a 16-bit carry out wraps at the top of memory
  always @* begin
    case (addr_mode)
      `MODE_EXT:     eff_addr = {byte1, byte2};
      `MODE_IX2:     eff_addr = {byte1, byte2} + {`PAGE0_HIGH, index};
      `MODE_IX1,
      `MODE_RMW_IX1: eff_addr = {`PAGE0_HIGH, byte1} + {`PAGE0_HIGH, index};
      `MODE_IX,
      `MODE_RMW_IX:  eff_addr = {`PAGE0_HIGH, index};
      default:       eff_addr = {`PAGE0_HIGH, byte1};
    endcase
  end

endmodule // ea_unit
`default_nettype wire

// ===== core/cpu_core.v
// Byte-wide CPU sequencer: address forming and instruction classes
`timescale 1ns/1ps
`default_nettype none
`include "cpu_addr_map.vh"

module cpu_core (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire [7:0]  mem_rdata,
  output reg  [15:0] mem_addr,
  output wire        mem_rd,
  output wire        mem_wr,
  output reg  [7:0]  mem_wdata,
  output wire [7:0]  acc,
  output wire [7:0]  idx,
  output wire [15:0] pc,
  output wire        flag_n,
  output wire        flag_z,
  output wire        flag_c,
  output wire        instr_done
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [8:0] S_FETCH   = 9'h001;
  localparam [8:0] S_DEC     = 9'h002;
  localparam [8:0] S_OP1     = 9'h004;
  localparam [8:0] S_OP2     = 9'h008;
  localparam [8:0] S_MEM     = 9'h010;
  localparam [8:0] S_EXEC    = 9'h020;
  localparam [8:0] S_WB      = 9'h040;
  localparam [8:0] S_PUSH_LO = 9'h080;
  localparam [8:0] S_PUSH_HI = 9'h100;

  reg  [8:0]  state_q, state_d;
  reg  [15:0] pc_q, pc_d;
  reg  [7:0]  acc_q, acc_d;
  reg  [7:0]  idx_q, idx_d;
  reg  [7:0]  sp_q, sp_d;
  reg  [7:0]  op_q, op_d;
  reg  [7:0]  op1_q, op1_d;
  reg  [7:0]  op2_q, op2_d;
  reg  [7:0]  res_q, res_d;
  reg         n_q, n_d;
  reg         z_q, z_d;
  reg         c_q, c_d;
  reg         done_q, done_d;
  reg         rd_req;
  reg         wr_req;
  reg         do_alu;
  reg         rmw_apply;
  reg  [7:0]  rmw_in;
  reg  [7:0]  rmw_val;
  reg  [7:0]  alu_m;
  reg  [8:0]  sum9;
  reg  [15:0] prod;
  wire [15:0] ea;
  wire [3:0]  mode;
  wire [3:0]  fn;
  wire [7:0]  bit_mask;
  wire        tested_bit;

  assign mode       = op_q[7:4];
  assign fn         = op_q[3:0];
  assign bit_mask   = 8'h01 << op_q[3:1];
  assign tested_bit = |(mem_rdata & bit_mask);

  // Bus strobes gated so a frozen core never repeats an access
  assign mem_rd     = rd_req & clk_en;
  assign mem_wr     = wr_req & clk_en;
  assign acc        = acc_q;
  assign idx        = idx_q;
  assign pc         = pc_q;
  assign flag_n     = n_q;
  assign flag_z     = z_q;
  assign flag_c     = c_q;
  assign instr_done = done_q;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Modes that carry a first operand byte after the opcode
  function has_op1;
    input [3:0] m;
    begin
      has_op1 = (m == `MODE_BITBR) || (m == `MODE_BITOP) || (m == `MODE_REL) ||
                (m == `MODE_RMW_DIR) || (m == `MODE_RMW_IX1) || (m == `MODE_IMM) ||
                (m == `MODE_DIR) || (m == `MODE_EXT) || (m == `MODE_IX2) ||
                (m == `MODE_IX1);
    end
  endfunction

  // Read-modify-write arithmetic; unknown codes act like a test
  function [7:0] rmw_fn;
    input [3:0] f;
    input [7:0] v;
    begin
      case (f)
        `FN_COM: rmw_fn = ~v;
        `FN_DEC: rmw_fn = v - 8'h01;
        `FN_INC: rmw_fn = v + 8'h01;
        `FN_CLR: rmw_fn = 8'h00;
        default: rmw_fn = v;
      endcase
    end
  endfunction

  function rmw_writes;
    input [3:0] f;
    begin
      rmw_writes = (f == `FN_COM) || (f == `FN_DEC) || (f == `FN_INC) || (f == `FN_CLR);
    end
  endfunction

  // Branch condition from the flags
  function br_cond;
    input [3:0] f;
    input       n;
    input       z;
    input       c;
    begin
      case (f)
        `BR_ALWAYS: br_cond = 1'b1;
        `BR_CC:     br_cond = ~c;
        `BR_CS:     br_cond = c;
        `BR_NE:     br_cond = ~z;
        `BR_EQ:     br_cond = z;
        default:    br_cond = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Address former
  // ----------------------------------------------------------------
  ea_unit ea_unit_i (
    .addr_mode (mode),
    .byte1     (op1_q),
    .byte2     (op2_q),
    .index     (idx_q),
    .eff_addr  (ea)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Reads return mem_rdata in the state after the strobe
  always @* begin
    state_d   = state_q;
    pc_d      = pc_q;
    acc_d     = acc_q;
    idx_d     = idx_q;
    sp_d      = sp_q;
    op_d      = op_q;
    op1_d     = op1_q;
    op2_d     = op2_q;
    res_d     = res_q;
    n_d       = n_q;
    z_d       = z_q;
    c_d       = c_q;
    done_d    = 1'b0;
    rd_req    = 1'b0;
    wr_req    = 1'b0;
    do_alu    = 1'b0;
    rmw_apply = 1'b0;
    rmw_in    = 8'h00;
    mem_addr  = pc_q;
    mem_wdata = res_q;
    prod      = 16'h0000;
    case (state_q)
      S_FETCH: begin
        rd_req  = 1'b1;
        pc_d    = pc_q + `PC_STEP;
        state_d = S_DEC;
      end
      S_DEC: begin
        op_d = mem_rdata;
        if (has_op1(mem_rdata[7:4])) begin
          rd_req  = 1'b1;
          pc_d    = pc_q + `PC_STEP;
          state_d = S_OP1;
        end else if (mem_rdata == `OP_MUL) begin
          prod    = acc_q * idx_q;
          idx_d   = prod[15:8];
          acc_d   = prod[7:0];
          c_d     = 1'b0;
          state_d = S_FETCH;
          done_d  = 1'b1;
        end else if (mem_rdata[7:4] == `MODE_INH_A ||
                     mem_rdata[7:4] == `MODE_INH_X) begin
          // Register forms of read-modify-write finish here
          rmw_apply = 1'b1;
          rmw_in    = (mem_rdata[7:4] == `MODE_INH_A) ? acc_q : idx_q;
          // Result formed here: rmw_val only settles below the case
          if (rmw_writes(mem_rdata[3:0]) && mem_rdata[7:4] == `MODE_INH_A)
            acc_d = rmw_fn(mem_rdata[3:0], acc_q);
          if (rmw_writes(mem_rdata[3:0]) && mem_rdata[7:4] == `MODE_INH_X)
            idx_d = rmw_fn(mem_rdata[3:0], idx_q);
          state_d = S_FETCH;
          done_d  = 1'b1;
        end else if (mem_rdata[7:4] == `MODE_RMW_IX ||
                     mem_rdata[7:4] == `MODE_IX) begin
          state_d = S_MEM;
        end else begin
          state_d = S_FETCH;                         // Undefined: one-byte no-op
          done_d  = 1'b1;
        end
      end
      S_OP1: begin
        op1_d = mem_rdata;
        if (mode == `MODE_BITBR || mode == `MODE_EXT || mode == `MODE_IX2) begin
          rd_req  = 1'b1;
          pc_d    = pc_q + `PC_STEP;
          state_d = S_OP2;
        end else if (mode == `MODE_REL) begin
          // pc already stands past the displacement byte
          if (br_cond(fn, n_q, z_q, c_q))
            pc_d = pc_q + {{8{mem_rdata[7]}}, mem_rdata};
          state_d = S_FETCH;
          done_d  = 1'b1;
        end else begin
          state_d = S_MEM;
        end
      end
      S_OP2: begin
        op2_d = mem_rdata;
        if (mode == `MODE_BITBR) begin
          rd_req   = 1'b1;
          mem_addr = {`PAGE0_HIGH, op1_q};
          state_d  = S_EXEC;
        end else begin
          state_d = S_MEM;
        end
      end
      S_MEM: begin
        if (mode == `MODE_BITOP || mode == `MODE_RMW_DIR ||
            mode == `MODE_RMW_IX1 || mode == `MODE_RMW_IX) begin
          rd_req   = 1'b1;
          mem_addr = ea;
          state_d  = S_EXEC;
        end else if (fn == `FN_JMP || fn == `FN_JSR) begin
          // Only address-field forms; indexed and immediate act as no-ops
          if ((mode == `MODE_DIR || mode == `MODE_EXT) && fn == `FN_JSR) begin
            state_d = S_PUSH_LO;
          end else begin
            if (mode == `MODE_DIR || mode == `MODE_EXT)
              pc_d = ea;
            state_d = S_FETCH;
            done_d  = 1'b1;
          end
        end else if (fn == `FN_STA || fn == `FN_STX) begin
          if (mode != `MODE_IMM) begin
            res_d   = (fn == `FN_STA) ? acc_q : idx_q;
            state_d = S_WB;
          end else begin
            state_d = S_FETCH;
            done_d  = 1'b1;
          end
        end else if (mode == `MODE_IMM) begin
          do_alu  = 1'b1;
          state_d = S_FETCH;
          done_d  = 1'b1;
        end else begin
          rd_req   = 1'b1;
          mem_addr = ea;
          state_d  = S_EXEC;
        end
      end
      S_EXEC: begin
        if (mode == `MODE_BITBR) begin
          c_d = tested_bit;
          if (tested_bit == ~op_q[0])
            pc_d = pc_q + {{8{op2_q[7]}}, op2_q};
          state_d = S_FETCH;
          done_d  = 1'b1;
        end else if (mode == `MODE_BITOP) begin
          res_d   = op_q[0] ? (mem_rdata & ~bit_mask) : (mem_rdata | bit_mask);
          state_d = S_WB;
        end else if (mode == `MODE_RMW_DIR || mode == `MODE_RMW_IX1 ||
                     mode == `MODE_RMW_IX) begin
          rmw_apply = 1'b1;
          rmw_in    = mem_rdata;
          res_d     = rmw_fn(fn, mem_rdata);
          if (rmw_writes(fn)) begin
            state_d = S_WB;
          end else begin
            state_d = S_FETCH;
            done_d  = 1'b1;
          end
        end else begin
          do_alu  = 1'b1;
          state_d = S_FETCH;
          done_d  = 1'b1;
        end
      end
      S_WB: begin
        wr_req   = 1'b1;
        mem_addr = ea;
        state_d  = S_FETCH;
        done_d   = 1'b1;
      end
      S_PUSH_LO: begin
        wr_req    = 1'b1;
        mem_addr  = {`PAGE0_HIGH, sp_q};
        mem_wdata = pc_q[7:0];
        sp_d      = sp_q - `SP_STEP;
        state_d   = S_PUSH_HI;
      end
      S_PUSH_HI: begin
        wr_req    = 1'b1;
        mem_addr  = {`PAGE0_HIGH, sp_q};
        mem_wdata = pc_q[15:8];
        sp_d      = sp_q - `SP_STEP;
        pc_d      = ea;
        state_d   = S_FETCH;
        done_d    = 1'b1;
      end
      default: begin
        state_d = S_FETCH;
      end
    endcase
    // Flags from read-modify-write; complement sets carry
    rmw_val = rmw_fn(op_d[3:0], rmw_in);
    if (rmw_apply) begin
      n_d = rmw_val[7];
      z_d = (rmw_val == 8'h00);
      if (op_d[3:0] == `FN_COM)
        c_d = 1'b1;
    end
    // Register/memory arithmetic, shared by immediate and memory forms
    alu_m = (mode == `MODE_IMM) ? op1_q : mem_rdata;
    sum9  = {1'b0, acc_q} + {1'b0, alu_m} + {8'h00, (fn == `FN_ADC) & c_q};
    if (do_alu) begin
      case (fn)
        `FN_LDA: acc_d = alu_m;
        `FN_AND: acc_d = acc_q & alu_m;
        `FN_LDX: idx_d = alu_m;
        `FN_ADD,
        `FN_ADC: begin
          acc_d = sum9[7:0];
          c_d   = sum9[8];
        end
        default: acc_d = acc_q;
      endcase
      if (fn == `FN_LDX) begin
        n_d = alu_m[7];
        z_d = (alu_m == 8'h00);
      end else if (fn == `FN_LDA || fn == `FN_AND || fn == `FN_ADD || fn == `FN_ADC) begin
        n_d = acc_d[7];
        z_d = (acc_d == 8'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Apart from reset, the whole core holds still while the clock enable is low
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= S_FETCH;
      pc_q    <= `RESET_PC;
      acc_q   <= 8'h00;
      idx_q   <= 8'h00;
      sp_q    <= `RESET_SP;
      op_q    <= 8'h00;
      op1_q   <= 8'h00;
      op2_q   <= 8'h00;
      res_q   <= 8'h00;
      n_q     <= 1'b0;
      z_q     <= 1'b0;
      c_q     <= 1'b0;
      done_q  <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      pc_q    <= pc_d;
      acc_q   <= acc_d;
      idx_q   <= idx_d;
      sp_q    <= sp_d;
      op_q    <= op_d;
      op1_q   <= op1_d;
      op2_q   <= op2_d;
      res_q   <= res_d;
      n_q     <= n_d;
      z_q     <= z_d;
      c_q     <= c_d;
      done_q  <= done_d;
    end
  end

endmodule // cpu_core
`default_nettype wire

// ===== dv/mem_model.sv
// Behavioural byte memory that answers the core one cycle after each read
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic        sys_clk,
  input  wire logic        clk_en,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output var  logic [7:0]  mem_rdata
);
  // Unused space holds a one-byte no-op, so a run past the program stays harmless;
  // set at declaration so it lands before the bench loads its first program
  logic [7:0] mem [0:65535] = '{default: 8'h9D};
  logic [7:0] data_q   = 8'h00;
  logic       ans_q    = 1'b0;
  int         wr_count = 0;

  // Fixed one-cycle answer, held while the core is frozen by its clock enable
  always @(posedge sys_clk) begin
    if (clk_en) begin
      ans_q <= mem_rd;
      if (mem_rd) data_q <= mem[mem_addr];
    end
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      wr_count      <= wr_count + 1;
    end
  end

  // Outside the answer cycle show the inverse, so stale data never looks valid
  assign mem_rdata = ans_q ? data_q : ~data_q;
endmodule // mem_model
`default_nettype wire

// ===== dv/cpu_core_assertions.sv
// Checker for the CPU core, watching only its ports
`timescale 1ns/1ps
`default_nettype none
module cpu_core_assertions (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic [7:0]  mem_rdata,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  idx,
  input wire logic [15:0] pc,
  input wire logic        flag_n,
  input wire logic        flag_z,
  input wire logic        flag_c,
  input wire logic        instr_done
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic       fetch_q, rst_q;
  logic [7:0] op_q, rdat_q;
  logic [7:0] cur_op, bit_mask;
  logic       mem_rmw;

  // Opcode tracking: the fetched byte arrives one cycle after the fetch;
  // the first fetch is the cycle after the last reset edge, when reset is already low
  always @(posedge sys_clk) begin
    if (clk_en) begin
      rst_q   <= sys_rst;
      fetch_q <= rst_q | instr_done;
      rdat_q  <= mem_rdata;
      if (fetch_q) op_q <= mem_rdata;
    end
  end

  // Decode of the instruction in flight
  assign cur_op   = fetch_q ? mem_rdata : op_q;
  assign bit_mask = 8'h01 << cur_op[3:1];
  assign mem_rmw  = (cur_op[7:4] == 4'h3) | (cur_op[7:5] == 3'b011);

  // Memory step of a modify: read, one cycle to alter, then write
  sequence rmw_cycle_s;
    mem_rd ##2 mem_wr && (mem_rmw || cur_op[7:4] == 4'h1);
  endsequence

  rd_wr_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  strobe_gate_a: assert property (!clk_en |-> !mem_rd && !mem_wr)
    else $error("strobe while clock enable low");
  done_pulse_a: assert property (instr_done && clk_en |=> !instr_done)
    else $error("completion pulse longer than one cycle");
  fetch_at_pc_a: assert property (instr_done && clk_en |-> mem_rd && mem_addr == pc)
    else $error("next fetch not at program counter");
  rmw_same_addr_a: assert property (rmw_cycle_s |-> mem_addr == $past(mem_addr, 2))
    else $error("modify wrote another address than it read");
  test_no_write_a: assert property (mem_wr |-> !(mem_rmw && cur_op[3:0] == 4'hD))
    else $error("negative or zero test wrote memory");
  bit_page_a: assert property (mem_wr && cur_op[7:4] == 4'h1 |-> mem_addr[15:8] == 8'h00)
    else $error("bit write outside the lowest page");
  bit_value_a: assert property (mem_wr && cur_op[7:4] == 4'h1 |->
      mem_wdata == (cur_op[0] ? rdat_q & ~bit_mask : rdat_q | bit_mask))
    else $error("bit write value wrong");
  bit_carry_a: assert property (instr_done && cur_op[7:4] == 4'h0 |->
      flag_c == rdat_q[cur_op[3:1]])
    else $error("carry not the tested bit");
  product_bytes_a: assert property ($past(clk_en) && instr_done && cur_op == 8'h42 |->
      {idx, acc} == {8'h00, $past(idx)} * {8'h00, $past(acc)} && !flag_c)
    else $error("product bytes wrong");
endmodule // cpu_core_assertions
`default_nettype wire

// ===== dv/tb_cpu_core.sv
// Testbench: short programs run on the core, results checked against a model
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_core;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en  = 1'b1;
  logic        stall   = 1'b0;
  logic [7:0]  mem_rdata, mem_wdata, acc, idx;
  logic [15:0] mem_addr, pc;
  logic        mem_rd, mem_wr, flag_n, flag_z, flag_c, instr_done;
  int          num_errors = 0;
  int          checks     = 0;
  logic [3:0]  rel_code [0:5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7};
  logic [3:0]  rmw_code [0:4] = '{4'h3, 4'hA, 4'hC, 4'hD, 4'hF};

  // ----------------------------------------------------------------
  // Clock, core and memory
  // ----------------------------------------------------------------
  always #25 sys_clk = ~sys_clk;

  cpu_core cpu_core_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .acc(acc), .idx(idx), .pc(pc), .flag_n(flag_n), .flag_z(flag_z),
    .flag_c(flag_c), .instr_done(instr_done)
  );

  mem_model mem_model_i (
    .sys_clk(sys_clk), .clk_en(clk_en), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wm(input logic [15:0] a, input logic [7:0] v);
    mem_model_i.mem[a] = v;
  endtask

  function automatic logic [7:0] rm(input logic [15:0] a);
    return mem_model_i.mem[a];
  endfunction

  function automatic int sx(input logic [7:0] d);
    return int'($signed(d));
  endfunction

  // Load at the reset address, reset, then wait for n completions (bounded)
  task automatic run(input logic [7:0] prog[$], input int n);
    int k;
    for (k = 0; k < prog.size(); k++) wm(16'h0100 + 16'(k), prog[k]);
    sys_rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("reset pc", pc, 16'h0100);
    chk("reset regs", {acc, idx}, 16'h0000);
    chk("reset flags", {flag_n, flag_z, flag_c}, 3'b000);
    sys_rst = 1'b0;
    k = 0;
    for (int t = 0; t < 200 && k < n; t++) begin
      @(posedge sys_clk);
      #1;
      // A frozen core keeps its completion pulse up, so count enabled edges only
      if (instr_done === 1'b1 && clk_en) k++;
      clk_en = (stall && k < n) ? (($urandom % 4) != 0) : 1'b1;
    end
    if (k < n) begin
      num_errors++;
      $display("Error completions expected %0d seen %0d", n, k);
      summarize();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  x, o, h, v, d, a, op;
    logic [7:0]  p[$];
    logic [15:0] ea;
    int          i, c, z, tk, e, w;
    void'($urandom(32'h36f9));
    // Indexed offsets; a decoy sits where a truncated or swapped sum would land
    for (i = 0; i < 6; i++) begin
      x = i == 0 ? 8'hFF : 8'hF0 | 8'($urandom);
      o = i == 0 ? 8'hFF : 8'h80 | 8'($urandom);
      h = 8'h20 | (8'($urandom) & 8'h1F);
      v = 8'($urandom);
      ea = i < 3 ? {8'h00, x} + {8'h00, o} : {h, o} + {8'h00, x};
      wm(i < 3 ? {8'h00, ea[7:0]} : {o, h} + {8'h00, x}, ~v);
      wm(ea, v);
      if (i < 3) run('{8'hAE, x, 8'hE6, o}, 2);
      else run('{8'hAE, x, 8'hD6, h, o}, 2);
      chk("indexed acc", acc, v);
      chk("indexed pc", pc, i < 3 ? 16'h0104 : 16'h0105);
    end
    // Direct load, add, store, carry add and mask, then the product of two registers;
    // the middle pass stalls the clock enable at random
    for (i = 0; i < 3; i++) begin
      d = 8'h10 | (8'($urandom) & 8'h6F);
      v = 8'($urandom);
      a = i == 0 ? 8'hFF : 8'($urandom);
      stall = i == 1;
      wm({8'h00, d}, v);
      wm({8'h01, d}, ~v);
      run('{8'hB6, d, 8'hAB, a, 8'hB7, d + 8'h01}, 3);
      e = v + a;
      chk("store sum", rm({8'h00, d + 8'h01}), 16'(e & 255));
      chk("add carry", flag_c, e > 255);
      run('{8'h43, 8'hA6, a, 8'hB9, d, 8'hB4, d}, 4);
      e = a + v + 1;
      chk("carry add and", {flag_c, acc}, 16'({e > 255, 8'(e) & v}));
      run('{8'hA6, a, 8'hAE, v, 8'h42}, 3);
      chk("product", {idx, acc}, {8'h00, a} * {8'h00, v});
    end
    stall = 1'b0;
    // Every relative condition with both carry and zero states
    for (i = 0; i < 24; i++) begin
      c = i % 2;
      z = (i / 2) % 2;
      op = {4'h2, rel_code[i / 4]};
      d = i < 2 ? (i ? 8'h7F : 8'h80) : 8'($urandom);
      p = {};
      if (c) p.push_back(8'h43);
      p = {p, 8'hA6, 8'(1 - z), op, d};
      run(p, 2 + c);
      tk = op[3:0] == 4'h0 || (op[3:0] == 4'h4 && !c) || (op[3:0] == 4'h5 && c)
        || (op[3:0] == 4'h6 && !z) || (op[3:0] == 4'h7 && z);
      chk("branch pc", pc, 16'(16'h0104 + c + (tk ? sx(d) : 0)));
    end
    // Memory modify codes; the test code must not write
    for (i = 0; i < 5; i++) begin
      op = {4'h3, rmw_code[i]};
      d = 8'h10 | (8'($urandom) & 8'h6F);
      v = i == 1 ? 8'h00 : 8'($urandom);
      wm({8'h00, d}, v);
      w = mem_model_i.wr_count;
      run('{op, d}, 1);
      case (op[3:0])
        4'h3:    a = ~v;
        4'hA:    a = v - 8'h01;
        4'hC:    a = v + 8'h01;
        4'hD:    a = v;
        default: a = 8'h00;
      endcase
      chk("modify value", rm({8'h00, d}), a);
      chk("modify zero", flag_z, a == 8'h00);
      chk("modify negative", flag_n, a[7]);
      chk("modify writes", 16'(mem_model_i.wr_count - w), op[3:0] != 4'hD);
    end
    // Each bit, both polarities: set or clear, then branch on it
    for (i = 0; i < 16; i++) begin
      d = i == 15 ? 8'hFF : 8'($urandom);
      v = 8'($urandom);
      x = 8'($urandom);
      wm({8'h00, d}, v);
      run('{{4'h1, 3'(i / 2), 1'(i % 2)}, d}, 1);
      a = i % 2 ? v & ~(8'h01 << (i / 2)) : v | (8'h01 << (i / 2));
      chk("bit op", rm({8'h00, d}), a);
      wm({8'h00, d}, v);
      run('{{4'h0, 3'(i / 2), 1'(i % 2)}, d, x}, 1);
      tk = v[i / 2] ^ (i % 2);
      chk("bit branch pc", pc, 16'(16'h0103 + (tk ? sx(x) : 0)));
      chk("bit carry", flag_c, v[i / 2]);
    end
    // Jumps ignore the index register; the subroutine form stacks its return
    for (i = 0; i < 2; i++) begin
      h = 8'h20 | (8'($urandom) & 8'h1F);
      o = 8'($urandom);
      wm(16'h00FE, 8'h00);
      wm(16'h00FF, 8'h00);
      run('{8'hAE, 8'($urandom), i ? 8'hCD : 8'hCC, h, o}, 2);
      chk("jump pc", pc, {h, o});
      if (i) chk("stacked return", {rm(16'h00FE), rm(16'h00FF)}, 16'h0105);
    end
    summarize();
  end
endmodule // tb_cpu_core

bind cpu_core cpu_core_assertions cpu_core_assertions_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .mem_rdata(mem_rdata),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .acc(acc), .idx(idx), .pc(pc), .flag_n(flag_n), .flag_z(flag_z),
  .flag_c(flag_c), .instr_done(instr_done)
);
`default_nettype wire
